// *** hw/hsq_pkg.sv ***
// Shared constants and types for the program sequencer
package hsq_pkg;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned PC_W        = 13;
   localparam int unsigned BANK_W      = 3;
   localparam int unsigned ADDR_W      = PC_W + BANK_W;
   localparam int unsigned INSN_W      = 16;
   localparam int unsigned STACK_DEPTH = 12;
   localparam int unsigned PAGE_LSB    = 8;
   localparam logic [15:0] RESET_VEC   = 16'h0000;
   localparam logic [15:0] INT_VEC     = 16'h0004;
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_PCL     = 8'h04;
   localparam logic [7:0]  REG_PC      = 8'h08;
   localparam logic [7:0]  REG_STAT    = 8'h0C;
   localparam logic [1:0]  CTRL_RESET  = 2'h1;
   localparam int unsigned CTRL_RUN    = 0;
   localparam int unsigned CTRL_IEN    = 1;
   localparam int unsigned FLG_C       = 0;
   localparam int unsigned FLG_AC      = 1;
   localparam int unsigned FLG_Z       = 2;
   localparam int unsigned FLG_OV      = 3;
   localparam int unsigned PCL_SRC_BIT = 8;
   localparam logic [3:0]  MISC_RET    = 4'h1;
   localparam logic [3:0]  MISC_INTERRUPT_RETURN   = 4'h2;
   typedef enum logic [1:0] {
      PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b10, PH_T4 = 2'b11
   } hsq_phase_type;
   typedef enum logic [2:0] {
      CL_MISC = 3'b000, CL_ALU = 3'b001, CL_JMP = 3'b010, CL_CALL = 3'b011,
      CL_SKIP = 3'b100, CL_PCL = 3'b101, CL_BANK = 3'b110, CL_EXT = 3'b111
   } hsq_class_type;
   typedef enum logic [4:0] {
      AL_ADD = 5'h00, AL_ADC = 5'h01, AL_SUB = 5'h02, AL_SBC = 5'h03,
      AL_AND = 5'h04, AL_OR  = 5'h05, AL_XOR = 5'h06, AL_CPL = 5'h07,
      AL_RR  = 5'h08, AL_RRC = 5'h09, AL_RL  = 5'h0A, AL_RLC = 5'h0B,
      AL_INC = 5'h0C, AL_DEC = 5'h0D, AL_DAA = 5'h0E, AL_MOV = 5'h0F
   } hsq_alu_type;
endpackage

// *** hw/hsq_if.sv ***
// Carriers between the sequencer core, its ALU and its return stack
`timescale 1ns/1ps
interface hsq_alu_if import hsq_pkg::*; ();
   hsq_alu_type func;
   logic [7:0]  a;
   logic [7:0]  b;
   logic        cin;
   logic        acin;
   logic [7:0]  res;
   logic [3:0]  flg;
   logic [3:0]  flg_we;
   modport core (output func, a, b, cin, acin, input res, flg, flg_we);
   modport alu  (input func, a, b, cin, acin, output res, flg, flg_we);
endinterface

interface hsq_stk_if import hsq_pkg::*; ();
   logic              push;
   logic              pop;
   logic [ADDR_W-1:0] din;
   logic [ADDR_W-1:0] dout;
   logic              full;
   modport core (output push, pop, din, input dout, full);
   modport stk  (input push, pop, din, output dout, full);
endinterface

// *** hw/hsq_alu.sv ***
// Eight-bit ALU with status flag outputs
`timescale 1ns/1ps
module hsq_alu import hsq_pkg::*; (
   hsq_alu_if.alu a_if
);
   logic [7:0] bx;
   logic       ci;
   logic [8:0] s;
   logic [4:0] h;
   logic [8:0] d;

   // One adder serves add, subtract, increment and decrement
   always_comb begin
      bx = a_if.b;
      ci = 1'b0;
      case (a_if.func)
         AL_ADC: ci = a_if.cin;
         AL_SUB: begin bx = ~a_if.b; ci = 1'b1; end
         AL_SBC: begin bx = ~a_if.b; ci = a_if.cin; end
         AL_INC: begin bx = 8'h00; ci = 1'b1; end
         AL_DEC: bx = 8'hFF;
         default: ;
      endcase
   end
   assign s = {1'b0, a_if.a} + {1'b0, bx} + {8'h00, ci};
   assign h = {1'b0, a_if.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};

   always_comb begin
      d = {1'b0, a_if.a};
      if (a_if.a[3:0] > 4'h9 || a_if.acin) d = d + 9'h006;
      if (d[7:4] > 4'h9 || d[8] || a_if.cin) d = d + 9'h060;
   end

   always_comb begin
      a_if.res    = a_if.a;
      a_if.flg    = 4'h0;
      a_if.flg_we = 4'h0;
      a_if.flg_we[FLG_Z] = 1'b1;
      case (a_if.func)
         AL_ADD, AL_ADC, AL_SUB, AL_SBC: begin
            a_if.res = s[7:0];
            a_if.flg[FLG_C]  = s[8];
            a_if.flg[FLG_AC] = h[4];
            a_if.flg[FLG_OV] = (a_if.a[7] == bx[7]) && (s[7] != a_if.a[7]);
            a_if.flg_we = 4'hF;
         end
         AL_AND: a_if.res = a_if.a & a_if.b;
         AL_OR:  a_if.res = a_if.a | a_if.b;
         AL_XOR: a_if.res = a_if.a ^ a_if.b;
         AL_CPL: a_if.res = ~a_if.a;
         AL_RR:  begin a_if.res = {a_if.a[0], a_if.a[7:1]}; a_if.flg_we = 4'h0; end
         AL_RL:  begin a_if.res = {a_if.a[6:0], a_if.a[7]}; a_if.flg_we = 4'h0; end
         AL_RRC: begin
            a_if.res = {a_if.cin, a_if.a[7:1]};
            a_if.flg[FLG_C] = a_if.a[0];
            a_if.flg_we = 4'h1;
         end
         AL_RLC: begin
            a_if.res = {a_if.a[6:0], a_if.cin};
            a_if.flg[FLG_C] = a_if.a[7];
            a_if.flg_we = 4'h1;
         end
         AL_INC, AL_DEC: a_if.res = s[7:0];
         AL_DAA: begin
            a_if.res = d[7:0];
            a_if.flg[FLG_C] = d[8] | a_if.cin;
            a_if.flg_we = 4'h1;
         end
         AL_MOV: begin a_if.res = a_if.b; a_if.flg_we = 4'h0; end
         default: a_if.flg_we = 4'h0;
      endcase
      a_if.flg[FLG_Z] = (a_if.res == 8'h00);
   end
endmodule

// *** hw/hsq_stack.sv ***
// Circular return-address stack, oldest entry lost on overflow
`timescale 1ns/1ps
module hsq_stack import hsq_pkg::*; #(
   parameter int unsigned DEPTH = STACK_DEPTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   hsq_stk_if.stk   s_if
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [ADDR_W-1:0] mem_r [DEPTH];
   logic [PW-1:0]     ptr_r;
   logic [PW-1:0]     ptr_inc;
   logic [PW-1:0]     ptr_dec;
   logic [PW:0]       lvl_r;

   assign ptr_inc   = (ptr_r == PW'(DEPTH - 1)) ? '0 : ptr_r + 1'b1;
   assign ptr_dec   = (ptr_r == '0) ? PW'(DEPTH - 1) : ptr_r - 1'b1;
   assign s_if.dout = mem_r[ptr_dec];
   assign s_if.full = (lvl_r == (PW + 1)'(DEPTH));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr_r <= '0;
         lvl_r <= '0;
      end else if (clk_en) begin
         if (s_if.push) begin
            ptr_r <= ptr_inc;
            if (!s_if.full) lvl_r <= lvl_r + 1'b1;
         end else if (s_if.pop && lvl_r != '0) begin
            ptr_r <= ptr_dec;
            lvl_r <= lvl_r - 1'b1;
         end
      end
   end

   // When full, the write slot is the oldest entry
   always_ff @(posedge hclk) begin
      if (clk_en && s_if.push) mem_r[ptr_r] <= s_if.din;
   end
endmodule

// *** hw/hsq_sequencer.sv ***
// Four-phase instruction sequencer with AHB-Lite register port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module hsq_sequencer import hsq_pkg::*; #(
   parameter int unsigned STK_DEPTH = STACK_DEPTH
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              clk_en,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [INSN_W-1:0] pm_data,
   output logic      [ADDR_W-1:0] pm_addr,
   output logic                   pm_rd,
   input  wire logic              irq_req,
   output logic                   int_ack,
   output logic      [3:0]        instruction_phases
);
   hsq_phase_type     ph_r;
   hsq_phase_type     ph_nxt;
   hsq_class_type     cls;
   logic [3:0]        ph_oh_r;
   logic [1:0]        ctrl_r;
   logic              run;
   logic              eoc;
   logic [PC_W-1:0]   pc_r;
   logic [PC_W-1:0]   pc_nxt;
   logic [BANK_W-1:0] bank_r;
   logic [BANK_W-1:0] bank_nxt;
   logic [ADDR_W-1:0] pc_full;
   logic [ADDR_W-1:0] tgt;
   logic [ADDR_W-1:0] ir_pc_r;
   logic [INSN_W-1:0] ir_r;
   logic              ir_ok_r;
   logic              ext_r;
   logic              pend_r;
   logic [7:0]        acc_r;
   logic [3:0]        flg_r;
   logic              pcl_req_r;
   logic [7:0]        pcl_val_r;
   logic              take_int;
   logic              flush;
   logic              hold;
   logic              pc_load;
   logic              acc_we;
   logic              ien_set;
   logic              ien_clr;
   logic              bus_go;
   logic              wr_pend_r;
   logic [7:0]        wr_addr_r;
   logic [31:0]       hrdata_r;
   logic              hreadyout_r;
   logic              hresp_r;
   logic [ADDR_W-1:0] pm_addr_r;
   logic              pm_rd_r;
   logic              int_ack_r;

   hsq_alu_if alu_if ();
   hsq_stk_if stk_if ();

   hsq_alu u_alu (
      .a_if (alu_if.alu)
   );

   hsq_stack #(
      .DEPTH (STK_DEPTH)
   ) u_stack (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_en  (clk_en),
      .s_if    (stk_if.stk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register decode helpers

   function automatic logic wr_hit(input logic [7:0] off);
      return wr_pend_r && (wr_addr_r == off);
   endfunction

   // Stack level is deliberately absent from the map
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      case (a)
         REG_CTRL: return {30'h0, ctrl_r};
         REG_PCL:  return {24'h0, pc_r[7:0]};
         REG_PC:   return {16'h0, pc_full};
         REG_STAT: return {19'h0, pend_r, flg_r, acc_r};
         default:  return 32'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Phase generator

   assign run     = ctrl_r[CTRL_RUN];
   assign eoc     = run && (ph_r == PH_T4);
   assign pc_full = {bank_r, pc_r};
   assign cls     = hsq_class_type'(ir_r[15:13]);

   always_comb begin
      case (ph_r)
         PH_T1:   ph_nxt = PH_T2;
         PH_T2:   ph_nxt = PH_T3;
         PH_T3:   ph_nxt = PH_T4;
         PH_T4:   ph_nxt = PH_T1;
         default: ph_nxt = PH_T1;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_r    <= PH_T1;
         ph_oh_r <= 4'h1;
         pm_rd_r <= 1'b1;
      end else if (clk_en && run) begin
         ph_r    <= ph_nxt;
         ph_oh_r <= 4'h1 << ph_nxt;
         pm_rd_r <= (ph_nxt == PH_T1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction-cycle decisions, all taken at the end of the fourth phase

   always_comb begin
      take_int     = 1'b0;
      flush        = 1'b0;
      hold         = 1'b0;
      pc_load      = 1'b0;
      acc_we       = 1'b0;
      ien_set      = 1'b0;
      ien_clr      = 1'b0;
      tgt          = pc_full;
      bank_nxt     = bank_r;
      stk_if.push  = 1'b0;
      stk_if.pop   = 1'b0;
      stk_if.din   = pc_full;
      alu_if.func  = hsq_alu_type'(ir_r[12:8]);
      alu_if.a     = acc_r;
      alu_if.b     = ir_r[7:0];
      alu_if.cin   = flg_r[FLG_C];
      alu_if.acin  = flg_r[FLG_AC];
      if (eoc) begin
         // Interrupt waits for a free slot and for an extended op to finish
         if (pend_r && ctrl_r[CTRL_IEN] && !stk_if.full && !ext_r) begin
            take_int    = 1'b1;
            stk_if.push = 1'b1;
            stk_if.din  = ir_ok_r ? ir_pc_r : pc_full;
            tgt         = INT_VEC;
            pc_load     = 1'b1;
            flush       = 1'b1;
            ien_clr     = 1'b1;
         end else if (pcl_req_r) begin
            // Discards the word in hand; software owns timing here
            tgt     = {bank_r, pc_r[PC_W-1:PAGE_LSB], pcl_val_r};
            pc_load = 1'b1;
            flush   = 1'b1;
         end else if (ir_ok_r) begin
            case (cls)
               CL_MISC: begin
                  if (ir_r[3:0] == MISC_RET || ir_r[3:0] == MISC_INTERRUPT_RETURN) begin
                     stk_if.pop = 1'b1;
                     tgt        = stk_if.dout;
                     pc_load    = 1'b1;
                     flush      = 1'b1;
                     ien_set    = (ir_r[3:0] == MISC_INTERRUPT_RETURN);
                  end
               end
               CL_ALU: acc_we = 1'b1;
               CL_EXT: begin
                  if (ext_r) acc_we = 1'b1;
                  else hold = 1'b1;
               end
               CL_SKIP: begin
                  acc_we = 1'b1;
                  flush  = (alu_if.res == 8'h00);
               end
               CL_JMP: begin
                  tgt     = {bank_r, ir_r[PC_W-1:0]};
                  pc_load = 1'b1;
                  flush   = 1'b1;
               end
               CL_CALL: begin
                  stk_if.push = 1'b1;
                  tgt         = {bank_r, ir_r[PC_W-1:0]};
                  pc_load     = 1'b1;
                  flush       = 1'b1;
               end
               CL_PCL: begin
                  tgt = {bank_r, pc_r[PC_W-1:PAGE_LSB],
                         ir_r[PCL_SRC_BIT] ? acc_r : ir_r[7:0]};
                  pc_load = 1'b1;
                  flush   = 1'b1;
               end
               CL_BANK: bank_nxt = ir_r[BANK_W-1:0];
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      if (pc_load) begin
         pc_nxt = tgt[PC_W-1:0];
      end else if (hold) begin
         pc_nxt = pc_r;
      end else begin
         pc_nxt = pc_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter, fetch and instruction register

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_r      <= RESET_VEC[PC_W-1:0];
         bank_r    <= RESET_VEC[ADDR_W-1:PC_W];
         pm_addr_r <= RESET_VEC;
         ir_r      <= '0;
         ir_pc_r   <= RESET_VEC;
         ir_ok_r   <= 1'b0;
         ext_r     <= 1'b0;
      end else if (clk_en && eoc) begin
         ext_r <= hold;
         if (!hold) begin
            pc_r      <= pc_nxt;
            bank_r    <= pc_load ? tgt[ADDR_W-1:PC_W] : bank_nxt;
            pm_addr_r <= {pc_load ? tgt[ADDR_W-1:PC_W] : bank_nxt, pc_nxt};
            ir_r      <= pm_data;
            ir_pc_r   <= pc_full;
            ir_ok_r   <= !flush;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r <= 8'h00;
         flg_r <= 4'h0;
      end else if (clk_en && acc_we) begin
         acc_r <= alu_if.res;
         flg_r <= (flg_r & ~alu_if.flg_we) | (alu_if.flg & alu_if.flg_we);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt capture and acknowledge

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r    <= 1'b0;
         int_ack_r <= 1'b0;
      end else if (clk_en) begin
         pend_r    <= irq_req | (pend_r & ~take_int);
         int_ack_r <= take_int;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states

   assign bus_go = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 8'h00;
         hrdata_r    <= 32'h0;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else if (clk_en) begin
         wr_pend_r   <= bus_go && hwrite;
         wr_addr_r   <= haddr[7:0];
         // Read data is a snapshot taken in the address phase
         hrdata_r    <= (bus_go && !hwrite) ? rd_word(haddr[7:0]) : 32'h0;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end
   end

   // Hardware enable changes override a same-cycle software write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RESET;
      end else if (clk_en) begin
         if (wr_hit(REG_CTRL)) ctrl_r <= hwdata[1:0];
         if (ien_clr) ctrl_r[CTRL_IEN] <= 1'b0;
         if (ien_set) ctrl_r[CTRL_IEN] <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pcl_req_r <= 1'b0;
         pcl_val_r <= 8'h00;
      end else if (clk_en) begin
         if (wr_hit(REG_PCL)) begin
            pcl_req_r <= 1'b1;
            pcl_val_r <= hwdata[7:0];
         end else if (eoc && !take_int) begin
            pcl_req_r <= 1'b0;
         end
      end
   end

   assign hrdata             = hrdata_r;
   assign hreadyout          = hreadyout_r;
   assign hresp              = hresp_r;
   assign pm_addr            = pm_addr_r;
   assign pm_rd              = pm_rd_r;
   assign int_ack            = int_ack_r;
   assign instruction_phases = ph_oh_r;
endmodule

// *** dv/hsq_seq_monitor.sv ***
// Port checker for the program sequencer
`timescale 1ns/1ps
module hsq_seq_monitor import hsq_pkg::*; (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              clk_en,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [ADDR_W-1:0] pm_addr,
   input wire logic              pm_rd,
   input wire logic              int_ack,
   input wire logic [3:0]        instruction_phases
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite && clk_en;
   endsequence
   sequence s_quiet;
      !int_ack [*3];
   endsequence
   a_phase_onehot: assert property ($onehot(instruction_phases))
      else $error("phase not one-hot");
   a_phase_turn: assert property (clk_en |=>
      instruction_phases == $past({instruction_phases[2:0], instruction_phases[3]}))
      else $error("phase did not rotate");
   a_phase_freeze: assert property (!clk_en |=>
      $stable(instruction_phases) && $stable(pm_addr))
      else $error("state moved while enable low");
   a_fetch_first: assert property (pm_rd |-> instruction_phases[0])
      else $error("fetch outside first phase");
   a_addr_holds: assert property (!instruction_phases[0] |-> $stable(pm_addr))
      else $error("fetch address moved mid cycle");
   a_reset_vec: assert property ($rose(hresetn) |-> pm_addr == RESET_VEC)
      else $error("first fetch not at zero");
   a_ack_vector: assert property (int_ack |-> pm_addr == INT_VEC)
      else $error("acknowledge without vector");
   a_ack_pulse: assert property (int_ack |=> s_quiet)
      else $error("acknowledge repeated");
   a_hidden_zero: assert property (
      s_rd ##0 haddr[7:0] > REG_STAT |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_pc_read: assert property (
      s_rd ##0 haddr[7:0] == REG_PC |=> hrdata == {16'h0000, $past(pm_addr)})
      else $error("counter read wrong");
   a_pcl_read: assert property (
      s_rd ##0 haddr[7:0] == REG_PCL |=> hrdata == {24'h0, $past(pm_addr[7:0])})
      else $error("low byte read wrong");
   a_resp_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
endmodule
bind hsq_sequencer hsq_seq_monitor u_hsq_seq_monitor (.hclk, .hresetn, .clk_en, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pm_addr, .pm_rd,
   .int_ack, .instruction_phases);

// *** dv/hsq_pmem_model.sv ***
// Program memory and interrupt source facing the sequencer
`timescale 1ns/1ps
module hsq_pmem_model import hsq_pkg::*; (
   input  wire logic              hclk,
   input  wire logic [ADDR_W-1:0] pm_addr,
   input  wire logic              pm_rd,
   input  wire logic              slow,
   input  wire logic              irq_fire,
   output logic      [INSN_W-1:0] pm_data,
   output logic                   irq_req
);
   logic [INSN_W-1:0] mem [0:255];
   // Slow part shows a wrong word early; the word is only due by the last phase
   always @(posedge hclk) begin
      pm_data <= (slow && pm_rd) ? ~mem[pm_addr[7:0]] : mem[pm_addr[7:0]];
      irq_req <= irq_fire;
   end
endmodule

// *** dv/cpu_program_sequencer_test.sv ***
// Directed test of the program sequencer through its register port
`timescale 1ns/1ps
module cpu_program_sequencer_test import hsq_pkg::*;;
   logic              hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
   logic              pm_rd, irq_req, int_ack, slow, irq_fire;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [INSN_W-1:0] pm_data;
   logic [ADDR_W-1:0] pm_addr, ack_pc;
   logic [3:0]        instruction_phases;
   logic [ADDR_W-1:0] trace [$];
   int                num_errors, checks, cyc, acks;
   // Word table {address, word}: jump, skip, call, return, page jump, vector
   localparam logic [23:0] PROG [14] = '{24'h002F3C, 24'h012005, 24'h024010,
      24'h04EC00, 24'h050002, 24'h102F01, 24'h118201, 24'h122F77, 24'h136030,
      24'h14A055, 24'h3020FF, 24'h310001, 24'h554055, 24'h604060};
   localparam logic [7:0] TR [18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11,
      8'h12, 8'h13, 8'h14, 8'h30, 8'h31, 8'h32, 8'h14, 8'h15, 8'h55, 8'h56, 8'h55, 8'h56};
   ////////////////////////////////////////////////////////////////////////////////
   hsq_sequencer u_hsq_sequencer (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .pm_data, .pm_addr, .pm_rd, .irq_req, .int_ack, .instruction_phases);
   hsq_pmem_model u_hsq_pmem_model (.hclk, .pm_addr, .pm_rd, .slow, .irq_fire,
      .pm_data, .irq_req);
   ////////////////////////////////////////////////////////////////////////////////
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (hresetn && pm_rd === 1'b1 && trace.size() < 18)
         trace.push_back(pm_addr);
      if (int_ack === 1'b1) begin
         acks++;
         ack_pc = pm_addr;
      end
      if (cyc == 3000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Address phase held until ready, then data phase held until ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] mask);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd & mask);
   endtask
   task automatic report_and_stop;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      slow = 1'b0;
      irq_fire = 1'b0;
      for (int i = 0; i < 256; i++) u_hsq_pmem_model.mem[i] = 16'h0000;
      foreach (PROG[i]) u_hsq_pmem_model.mem[PROG[i][23:16]] = PROG[i][15:0];
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk("control", REG_CTRL, 32'h1, 32'hFFFFFFFF);
      rchk("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF);
      $display("test registers done");
      while (trace.size() < 18) @(posedge hclk);
      foreach (TR[i]) chk("fetch", {24'h0, TR[i]}, {16'h0, trace[i]});
      rchk("status", REG_STAT, 32'h00FF, 32'h1FFF);
      rchk("counter", REG_PC, 32'h0054, 32'hFFFE);
      rchk("low byte", REG_PCL, 32'h0054, 32'hFFFE);
      $display("test program flow done");
      // Slow memory from here on: wrong word through the phase after the fetch phase
      slow <= 1'b1;
      bus(1'b1, REG_PCL, 32'h60);
      while (pm_addr !== 16'h0060) @(posedge hclk);
      rchk("page jump", REG_PC, 32'h0060, 32'hFFFE);
      // Enable low for nine edges: phase and fetch address must not move
      clk_en <= 1'b0;
      @(posedge hclk);
      rd = {12'h0, instruction_phases, pm_addr};
      repeat (8) @(posedge hclk);
      chk("frozen", rd, {12'h0, instruction_phases, pm_addr});
      clk_en <= 1'b1;
      $display("test page jump done");
      irq_fire <= 1'b1;
      @(posedge hclk);
      irq_fire <= 1'b0;
      repeat (12) @(posedge hclk);
      chk("masked acks", 32'h0, 32'(acks));
      rchk("pending", REG_STAT, 32'h1000, 32'h1000);
      bus(1'b1, REG_CTRL, 32'h3);
      while (acks == 0) @(posedge hclk);
      chk("vector", {16'h0, INT_VEC}, {16'h0, ack_pc});
      @(posedge hclk);
      while (pm_addr[15:1] !== 15'h0030) @(posedge hclk);
      rchk("enable back", REG_CTRL, 32'h3, 32'h3);
      // Service routine ran a two-cycle increment of 0xFF: zero result, Z only
      rchk("pending gone", REG_STAT, 32'h0400, 32'h1FFF);
      chk("acks", 32'h1, 32'(acks));
      $display("test interrupt done");
      report_and_stop();
   end
endmodule
